//--- bus_cycle_source.sv
// model of the monitored processor bus: one strobe per bus cycle
// assumes issue() is called right after a rising edge of ref_clk
`timescale 1ns/100ps
module bus_cycle_source #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 16,
   parameter int STAT_W = 4,
   parameter int GAP = 2
)(
   // clock
   input wire logic ref_clk,
   // monitored bus
   output logic bus_cycle_strobe,
   output logic [ADDR_W-1:0] bus_address,
   output logic [DATA_W-1:0] bus_data,
   output logic [STAT_W-1:0] bus_status
);
   initial
   begin
      bus_cycle_strobe = 1'b0;
      bus_address = '0;
      bus_data = '0;
      bus_status = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   // idle lines show the inverse so a stale value can never match
   task automatic issue(input logic [ADDR_W-1:0] a,
      input logic [DATA_W-1:0] d, input logic [STAT_W-1:0] s);
      bus_cycle_strobe <= 1'b1;
      bus_address <= a;
      bus_data <= d;
      bus_status <= s;
      @(posedge ref_clk);
      bus_cycle_strobe <= 1'b0;
      bus_address <= ~a;
      bus_data <= ~d;
      bus_status <= ~s;
      repeat (GAP) @(posedge ref_clk);
   endtask
endmodule

//--- event_counter_defines.svh
// constants for the time-stamp compare and trigger block
// assumes inclusion by bare name from the package and the design modules
//
// What this block does
// RULE_01 - sample address, data, status once per cycle
// RULE_02 - condition combines address, data, status matches
// RULE_03 - counter comparator observes absolute counter value
// RULE_04 - position 4: millisecond tick, trigger clears counter
// RULE_05 - comparator loaded with converted, reordered bit pattern
// RULE_06 - address match may clear counter and switch group
// RULE_07 - only active group statements are evaluated
// RULE_08 - counter match in active group halts emulation
// RULE_09 - time base no shorter than a bus cycle
// RULE_10 - position F: count rising trigger pulses
// RULE_11 - counter match needs every bit equal
`ifndef EVENT_COUNTER_DEFINES_SVH
`define EVENT_COUNTER_DEFINES_SVH

// register word addresses
`define REG_CTRL 4'h0
`define REG_STATUS 4'h1
`define REG_MASK 4'h2
`define REG_ADDR_CMP 4'h3
`define REG_DATA_CMP 4'h4
`define REG_STAT_CMP 4'h5
`define REG_CNT_CMP 4'h6
`define REG_STMT 4'h7
`define REG_COUNT 4'h8
`define REG_INDEX_W 4

// control fields
`define CTRL_RUN_BIT 0
`define CTRL_GROUP_BIT 1
`define CTRL_BASE_LSB 4
`define CTRL_BASE_W 4

// time-base selector positions
`define BASE_MS 4'h4
`define BASE_EVENTS 4'hF

// statement word fields, one byte per group
`define STMT_USE_ADDR 0
`define STMT_USE_DATA 1
`define STMT_USE_STAT 2
`define STMT_USE_CNT 3
`define STMT_TRIGGER 4
`define STMT_SWITCH 5
`define STMT_TRACE 6
`define STMT_HALT 7

// status bits
`define ST_TRIGGER 0
`define ST_SWITCH 1
`define ST_TRACE 2
`define ST_HALT 3
`define ST_W 4

// timing
`define CLK_HZ 25000000
`define MS_PER_TICK_NUM 1
`define MS_TICK_CYCLES (`CLK_HZ / 1000 * `MS_PER_TICK_NUM)

`endif

//--- event_counter_pkg.sv
// types shared by the time-stamp compare and trigger block
// assumes event_counter_defines.svh sits in the same folder
`include "event_counter_defines.svh"
package event_counter_pkg;
   typedef enum logic [1:0]
   {
      BUS_IDLE = 2'b00,
      BUS_READ_ACK = 2'b01,
      BUS_WRITE_ACK = 2'b10
   } bus_state_t;
endpackage

//--- stamp_counter.sv
// time-stamp counter with selectable time base
// assumes one clock, synchronous active-high reset, 25 MHz
`timescale 1ns/100ps
`include "event_counter_defines.svh"
module stamp_counter #(
   parameter int COUNT_W = 16,
   parameter int TICK_CYCLES = `MS_TICK_CYCLES
)(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   // control
   input wire logic [3:0] time_base,
   input wire logic event_trigger_pulse,
   // state
   output logic [COUNT_W-1:0] count_q
);
   logic [COUNT_W-1:0] count_d;
   logic [31:0] tick_q;
   logic [31:0] tick_d;
   logic trig_prev_q;
   logic trig_prev_d;

   always_comb
   begin
      count_d = count_q;
      tick_d = tick_q;
      trig_prev_d = event_trigger_pulse;
      if (time_base == `BASE_MS)
      begin
         // trigger wins over the tick so the clear is never lost
         if (event_trigger_pulse)
         begin
            count_d = '0; // [RULE_04]
            tick_d = '0;
         end
         else if (tick_q == 32'(TICK_CYCLES - 1))
         begin
            count_d = count_q + 1'b1; // [RULE_04]
            tick_d = '0;
         end
         else
            tick_d = tick_q + 32'h00000001;
      end
      else if (time_base == `BASE_EVENTS)
      begin
         tick_d = '0;
         if (event_trigger_pulse && !trig_prev_q)
            count_d = count_q + 1'b1; // [RULE_10]
      end
      else
         tick_d = '0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         count_q <= '0;
         tick_q <= '0;
         trig_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         count_q <= count_d;
         tick_q <= tick_d;
         trig_prev_q <= trig_prev_d;
      end
   end

   a_base_clear: assert property (@(posedge ref_clk) // [RULE_04]
      disable iff (rst)
      clk_en && time_base == `BASE_MS && event_trigger_pulse
      |=> count_q == '0)
      else $error("counter not cleared by trigger");
   a_event_step: assert property (@(posedge ref_clk) // [RULE_10]
      disable iff (rst)
      clk_en && time_base == `BASE_EVENTS && event_trigger_pulse
      && !trig_prev_q |=> count_q == $past(count_q) + 1'b1)
      else $error("occurrence count did not step");
   a_event_level: assert property (@(posedge ref_clk) // [RULE_10]
      disable iff (rst)
      clk_en && time_base == `BASE_EVENTS && trig_prev_q
      |=> count_q == $past(count_q))
      else $error("counter stepped on held trigger");
   c_event_count: cover property (@(posedge ref_clk) disable iff (rst)
      time_base == `BASE_EVENTS && count_q == COUNT_W'(2));
endmodule

//--- timestamp_compare_trigger.sv
// event monitor: bus-cycle sampling, grouped conditions, actions
// assumes Avalon-MM master on ref_clk, one monitored bus cycle per strobe
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "event_counter_defines.svh"
module timestamp_compare_trigger #(
   parameter int ADDR_W = 20,
   parameter int DATA_W = 16,
   parameter int STAT_W = 4,
   parameter int COUNT_W = 16,
   parameter int TICK_CYCLES = `MS_TICK_CYCLES
)(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic clk_en,
   // register bus
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // monitored processor bus
   input wire logic bus_cycle_strobe,
   input wire logic [ADDR_W-1:0] bus_address,
   input wire logic [DATA_W-1:0] bus_data,
   input wire logic [STAT_W-1:0] bus_status,
   // actions and interrupt
   output logic event_trigger_pulse,
   output logic event_group_switch,
   output logic trace_record_action,
   output logic halt_emulation_action,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////
   // registers
   logic [31:0] ctrl_q, ctrl_d;
   logic [`ST_W-1:0] status_q, status_d;
   logic [`ST_W-1:0] mask_q, mask_d;
   logic [ADDR_W-1:0] addr_cmp_q, addr_cmp_d;
   logic [DATA_W-1:0] data_cmp_q, data_cmp_d;
   logic [STAT_W-1:0] stat_cmp_q, stat_cmp_d;
   logic [COUNT_W-1:0] counter_value_comparator_q;
   logic [COUNT_W-1:0] counter_value_comparator_d;
   logic [15:0] stmt_q, stmt_d;
   logic [31:0] rdata_q, rdata_d;
   logic wait_q, wait_d;
   logic irq_q, irq_d;
   event_counter_pkg::bus_state_t bus_q, bus_d;
   // sampling and actions
   logic [ADDR_W-1:0] s_addr_q, s_addr_d;
   logic [DATA_W-1:0] s_data_q, s_data_d;
   logic [STAT_W-1:0] s_stat_q, s_stat_d;
   logic [COUNT_W-1:0] s_count_q, s_count_d;
   logic sample_q, sample_d;
   logic group_q, group_d;
   logic trig_q, trig_d;
   logic sw_q, sw_d;
   logic trc_q, trc_d;
   logic halt_q, halt_d;
   logic [COUNT_W-1:0] count_q;
   logic [7:0] stmt;
   logic addr_hit, data_hit, stat_hit, cnt_hit, fire;
   logic [`ST_W-1:0] events;

   ////////////////////////////////////////////////////////////////////////
   // time-stamp counter
   stamp_counter #(
      .COUNT_W(COUNT_W),
      .TICK_CYCLES(TICK_CYCLES)
   ) stamp_counter_inst (
      .ref_clk(ref_clk),
      .rst(rst),
      .clk_en(clk_en),
      .time_base(ctrl_q[`CTRL_BASE_LSB +: `CTRL_BASE_W]),
      .event_trigger_pulse(trig_q),
      .count_q(count_q)
   );

   ////////////////////////////////////////////////////////////////////////
   // condition evaluation
   always_comb
   begin
      // one statement byte per group; only the active one is used
      stmt = group_q ? stmt_q[15:8] : stmt_q[7:0]; // [RULE_07]
      addr_hit = s_addr_q == addr_cmp_q;
      data_hit = s_data_q == data_cmp_q;
      stat_hit = s_stat_q == stat_cmp_q;
      // raw reordered bits compared; software converts the count
      cnt_hit = s_count_q == counter_value_comparator_q; // [RULE_03] [RULE_05] [RULE_11]
      // unused terms are don't-care; all-off never fires
      fire = sample_q && ctrl_q[`CTRL_RUN_BIT]
         && (stmt[3:0] != 4'h0)
         && (!stmt[`STMT_USE_ADDR] || addr_hit)
         && (!stmt[`STMT_USE_DATA] || data_hit)
         && (!stmt[`STMT_USE_STAT] || stat_hit)
         && (!stmt[`STMT_USE_CNT] || cnt_hit); // [RULE_02]
   end

   always_comb
   begin
      s_addr_d = s_addr_q;
      s_data_d = s_data_q;
      s_stat_d = s_stat_q;
      s_count_d = s_count_q;
      sample_d = bus_cycle_strobe;
      if (bus_cycle_strobe)
      begin
         // one snapshot per bus cycle, all conditions use it
         s_addr_d = bus_address; // [RULE_01]
         s_data_d = bus_data;
         s_stat_d = bus_status;
         s_count_d = count_q;
      end
      trig_d = fire && stmt[`STMT_TRIGGER]; // [RULE_06]
      sw_d = fire && stmt[`STMT_SWITCH];
      trc_d = fire && stmt[`STMT_TRACE];
      halt_d = fire && stmt[`STMT_HALT]; // [RULE_08]
      group_d = sw_d ? ~group_q : group_q; // [RULE_06]
      if (bus_q == event_counter_pkg::BUS_IDLE && avs_write
         && avs_address == `REG_CTRL)
         group_d = avs_writedata[`CTRL_GROUP_BIT];
   end

   ////////////////////////////////////////////////////////////////////////
   // register bus slave and interrupt
   always_comb
   begin
      ctrl_d = ctrl_q;
      mask_d = mask_q;
      addr_cmp_d = addr_cmp_q;
      data_cmp_d = data_cmp_q;
      stat_cmp_d = stat_cmp_q;
      counter_value_comparator_d = counter_value_comparator_q;
      stmt_d = stmt_q;
      rdata_d = rdata_q;
      bus_d = event_counter_pkg::BUS_IDLE;
      wait_d = 1'b1;
      events = {halt_d, trc_d, sw_d, trig_d};
      status_d = status_q;
      if (bus_q == event_counter_pkg::BUS_IDLE && avs_write)
      begin
         bus_d = event_counter_pkg::BUS_WRITE_ACK;
         wait_d = 1'b0;
         unique case (avs_address)
            `REG_CTRL: ctrl_d = avs_writedata;
            `REG_STATUS: status_d = status_q & ~avs_writedata[`ST_W-1:0];
            `REG_MASK: mask_d = avs_writedata[`ST_W-1:0];
            `REG_ADDR_CMP: addr_cmp_d = avs_writedata[ADDR_W-1:0];
            `REG_DATA_CMP: data_cmp_d = avs_writedata[DATA_W-1:0];
            `REG_STAT_CMP: stat_cmp_d = avs_writedata[STAT_W-1:0];
            `REG_CNT_CMP:
               counter_value_comparator_d = avs_writedata[COUNT_W-1:0]; // [RULE_05]
            `REG_STMT: stmt_d = avs_writedata[15:0];
            default: ;
         endcase
      end
      else if (bus_q == event_counter_pkg::BUS_IDLE && avs_read)
      begin
         bus_d = event_counter_pkg::BUS_READ_ACK;
         wait_d = 1'b0;
         unique case (avs_address)
            `REG_CTRL: rdata_d = {ctrl_q[31:2], group_q, ctrl_q[0]};
            `REG_STATUS: rdata_d = 32'(status_q);
            `REG_MASK: rdata_d = 32'(mask_q);
            `REG_ADDR_CMP: rdata_d = 32'(addr_cmp_q);
            `REG_DATA_CMP: rdata_d = 32'(data_cmp_q);
            `REG_STAT_CMP: rdata_d = 32'(stat_cmp_q);
            `REG_CNT_CMP: rdata_d = 32'(counter_value_comparator_q);
            `REG_STMT: rdata_d = 32'(stmt_q);
            `REG_COUNT: rdata_d = 32'(count_q);
            default: rdata_d = 32'h00000000;
         endcase
      end
      // set wins over a same-cycle write-one clear
      status_d = status_d | events;
      irq_d = |(status_d & mask_d);
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         ctrl_q <= 32'h00000000;
         status_q <= '0;
         mask_q <= '0;
         addr_cmp_q <= '0;
         data_cmp_q <= '0;
         stat_cmp_q <= '0;
         counter_value_comparator_q <= '0;
         stmt_q <= 16'h0000;
         rdata_q <= 32'h00000000;
         wait_q <= 1'b1;
         irq_q <= 1'b0;
         bus_q <= event_counter_pkg::BUS_IDLE;
         s_addr_q <= '0;
         s_data_q <= '0;
         s_stat_q <= '0;
         s_count_q <= '0;
         sample_q <= 1'b0;
         group_q <= 1'b0;
         trig_q <= 1'b0;
         sw_q <= 1'b0;
         trc_q <= 1'b0;
         halt_q <= 1'b0;
      end
      else if (clk_en)
      begin
         ctrl_q <= ctrl_d;
         status_q <= status_d;
         mask_q <= mask_d;
         addr_cmp_q <= addr_cmp_d;
         data_cmp_q <= data_cmp_d;
         stat_cmp_q <= stat_cmp_d;
         counter_value_comparator_q <= counter_value_comparator_d;
         stmt_q <= stmt_d;
         rdata_q <= rdata_d;
         wait_q <= wait_d;
         irq_q <= irq_d;
         bus_q <= bus_d;
         s_addr_q <= s_addr_d;
         s_data_q <= s_data_d;
         s_stat_q <= s_stat_d;
         s_count_q <= s_count_d;
         sample_q <= sample_d;
         group_q <= group_d;
         trig_q <= trig_d;
         sw_q <= sw_d;
         trc_q <= trc_d;
         halt_q <= halt_d;
      end
   end

   assign avs_readdata = rdata_q;
   assign avs_waitrequest = wait_q;
   assign event_trigger_pulse = trig_q;
   assign event_group_switch = sw_q;
   assign trace_record_action = trc_q;
   assign halt_emulation_action = halt_q;
   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_sample_once: assert property (@(posedge ref_clk) // [RULE_01]
      disable iff (rst)
      clk_en && bus_cycle_strobe |=> s_addr_q == $past(bus_address))
      else $error("bus sample not taken");
   a_sample_count: assert property (@(posedge ref_clk) // [RULE_03]
      disable iff (rst)
      clk_en && bus_cycle_strobe |=> s_count_q == $past(count_q))
      else $error("counter value not sampled with bus cycle");
   // a used term that misses must block every action
   a_cond_addr: assert property (@(posedge ref_clk) // [RULE_02]
      disable iff (rst)
      clk_en && stmt[`STMT_USE_ADDR] && s_addr_q != addr_cmp_q
      |=> !(event_trigger_pulse || event_group_switch
      || trace_record_action || halt_emulation_action))
      else $error("fired without address match");
   a_count_exact: assert property (@(posedge ref_clk) // [RULE_11]
      disable iff (rst)
      clk_en && stmt[`STMT_USE_CNT]
      && s_count_q != counter_value_comparator_q
      |=> !halt_emulation_action)
      else $error("halt on unequal counter bits");
   a_cnt_cond: assert property (@(posedge ref_clk) // [RULE_03]
      disable iff (rst)
      clk_en && stmt[`STMT_USE_CNT]
      && s_count_q != counter_value_comparator_q
      |=> !(event_trigger_pulse || event_group_switch
      || trace_record_action))
      else $error("fired without counter match");
   a_trig_group: assert property (@(posedge ref_clk) // [RULE_06]
      disable iff (rst)
      clk_en && fire && stmt[`STMT_TRIGGER] && stmt[`STMT_SWITCH]
      && !(avs_write && bus_q == event_counter_pkg::BUS_IDLE)
      |=> event_trigger_pulse && group_q != $past(group_q))
      else $error("trigger and group switch not together");
   // active byte without terms stays silent whatever the other holds
   a_group_select: assert property (@(posedge ref_clk) // [RULE_07]
      disable iff (rst)
      clk_en && (group_q ? stmt_q[11:8] : stmt_q[3:0]) == 4'h0
      |=> !(event_trigger_pulse || event_group_switch
      || trace_record_action || halt_emulation_action))
      else $error("inactive group statement used");
   a_halt_on_count: assert property (@(posedge ref_clk) // [RULE_08]
      disable iff (rst)
      clk_en && sample_q && ctrl_q[`CTRL_RUN_BIT] && stmt == 8'h88
      && s_count_q == counter_value_comparator_q
      |=> halt_emulation_action)
      else $error("no halt on counter match");
   a_wait_one: assert property (@(posedge ref_clk) disable iff (rst)
      clk_en && !avs_waitrequest |=> clk_en |-> avs_waitrequest)
      else $error("waitrequest low two cycles");
   a_wait_answer: assert property (@(posedge ref_clk) disable iff (rst)
      clk_en && bus_q == event_counter_pkg::BUS_IDLE
      && (avs_read || avs_write) |=> !avs_waitrequest)
      else $error("request not answered in one cycle");
   a_read_unmapped: assert property (@(posedge ref_clk) disable iff (rst)
      clk_en && bus_q == event_counter_pkg::BUS_IDLE && avs_read
      && !avs_write && avs_address > `REG_COUNT
      |=> avs_readdata == 32'h00000000)
      else $error("unmapped read not zero");
   // an event racing a write-one clear must still leave its bit set
   a_set_wins: assert property (@(posedge ref_clk) disable iff (rst)
      clk_en && events != '0
      |=> (status_q & $past(events)) == $past(events))
      else $error("status event lost");
   a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
      irq == (|(status_q & mask_q)))
      else $error("interrupt does not follow status and mask");
   c_halt: cover property (@(posedge ref_clk) halt_emulation_action);
   c_switch: cover property (@(posedge ref_clk) event_group_switch);
   c_irq: cover property (@(posedge ref_clk) irq);
   c_clear_switch: cover property (@(posedge ref_clk)
      event_trigger_pulse && event_group_switch);
endmodule

//--- timestamp_compare_trigger_test.sv
// self-checking bench for the time-stamp compare and trigger block
// assumes the design files and bus_cycle_source.sv are compiled first
`timescale 1ns/100ps
`include "event_counter_defines.svh"
module timestamp_compare_trigger_test;
   localparam int TICK = 4;
   logic ref_clk, rst, clk_en;
   logic [3:0] avs_address;
   logic avs_read, avs_write;
   logic [31:0] avs_writedata, avs_readdata;
   logic avs_waitrequest;
   logic bus_cycle_strobe;
   logic [19:0] bus_address;
   logic [15:0] bus_data;
   logic [3:0] bus_status;
   logic event_trigger_pulse, event_group_switch;
   logic trace_record_action, halt_emulation_action, irq;
   int err_total = 0;
   int n_tests = 0;
   int seen_cnt [4] = '{0, 0, 0, 0};
   int exp_cnt [4] = '{0, 0, 0, 0};
   logic [31:0] rng_q = 32'h00013014;
   ////////////////////////////////////////////////////////////////////////
   timestamp_compare_trigger #(.TICK_CYCLES(TICK))
   timestamp_compare_trigger_inst (
      .ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .bus_cycle_strobe(bus_cycle_strobe), .bus_address(bus_address),
      .bus_data(bus_data), .bus_status(bus_status),
      .event_trigger_pulse(event_trigger_pulse),
      .event_group_switch(event_group_switch),
      .trace_record_action(trace_record_action),
      .halt_emulation_action(halt_emulation_action), .irq(irq));
   bus_cycle_source bus_cycle_source_inst (
      .ref_clk(ref_clk), .bus_cycle_strobe(bus_cycle_strobe),
      .bus_address(bus_address), .bus_data(bus_data),
      .bus_status(bus_status));
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end
   // pulse widths count too: a two-cycle pulse counts twice
   always @(negedge ref_clk)
   begin
      if (event_trigger_pulse === 1'b1)
         seen_cnt[0]++;
      if (event_group_switch === 1'b1)
         seen_cnt[1]++;
      if (trace_record_action === 1'b1)
         seen_cnt[2]++;
      if (halt_emulation_action === 1'b1)
         seen_cnt[3]++;
   end
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      rng_q = rng_q ^ (rng_q << 13);
      rng_q = rng_q ^ (rng_q >> 17);
      rng_q = rng_q ^ (rng_q << 5);
      return rng_q;
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         err_total++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic final_report();
      if (err_total == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic av_xfer(input logic wr, input logic [3:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge ref_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= ~wr;
      // answer and read data are taken at the edge that sees it low
      @(posedge ref_clk);
      while (avs_waitrequest !== 1'b0)
         @(posedge ref_clk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      av_xfer(1'b1, a, d, q);
   endtask
   task automatic av_rd(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] q;
      av_xfer(1'b0, a, 32'h0, q);
      check(q, exp);
   endtask
   task automatic cycle(input logic [19:0] a, input logic [15:0] d,
      input logic [3:0] s);
      @(posedge ref_clk);
      bus_cycle_source_inst.issue(a, d, s);
   endtask
   task automatic pulses();
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      for (int i = 0; i < 4; i++)
         check(32'(seen_cnt[i]), 32'(exp_cnt[i]));
   endtask
   task automatic settle_irq(input logic exp);
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      check({31'h0, irq}, {31'h0, exp});
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6000) @(posedge ref_clk);
      err_total++;
      final_report();
   end
   initial
   begin
      logic [19:0] a0;
      logic [15:0] d0;
      logic [3:0] s0;
      logic [31:0] c1;
      int n;
      rst = 1'b1;
      clk_en = 1'b1;
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      check({31'h0, avs_waitrequest}, 32'h1);
      for (int i = 0; i < 16; i++)
         av_rd(4'(i), 32'h0);
      a0 = 20'(rnd());
      d0 = 16'(rnd());
      s0 = 4'(rnd());
      av_wr(`REG_ADDR_CMP, {12'h0, a0});
      av_wr(`REG_DATA_CMP, {16'h0, d0});
      av_wr(`REG_STAT_CMP, {28'h0, s0});
      av_wr(4'hC, rnd());
      av_rd(`REG_ADDR_CMP, {12'h0, a0});
      av_rd(`REG_DATA_CMP, {16'h0, d0});
      av_rd(`REG_STAT_CMP, {28'h0, s0});
      av_rd(4'hC, 32'h0);
      // occurrence counting: each address hit is one trigger
      n = 3 + int'(rnd() % 4);
      av_wr(`REG_STMT, 32'h00008811);
      av_wr(`REG_CNT_CMP, 32'(n) ^ 32'h00000100);
      av_wr(`REG_CTRL, 32'h000000F1);
      for (int i = 0; i < n; i++)
         cycle(a0, 16'(rnd()), 4'(rnd()));
      cycle(a0 ^ 20'h00001, d0, s0);
      exp_cnt[0] += n;
      pulses();
      av_rd(`REG_COUNT, 32'(n));
      // group 1: address hit ignored, counter one bit off
      av_wr(`REG_CTRL, 32'h000000F3);
      cycle(a0, d0, s0);
      pulses();
      av_wr(`REG_CNT_CMP, 32'(n));
      cycle(20'(rnd()), 16'(rnd()), 4'(rnd()));
      exp_cnt[3]++;
      pulses();
      av_rd(`REG_COUNT, 32'(n));
      // every mix of address, data and status hits
      av_wr(`REG_CTRL, 32'h000000F1);
      av_wr(`REG_STMT, 32'h00000047);
      for (int k = 0; k < 8; k++)
         cycle(k[0] ? a0 : ~a0, k[1] ? d0 : ~d0, k[2] ? s0 : ~s0);
      exp_cnt[2]++;
      pulses();
      // sticky status, mask and write-one-to-clear
      av_rd(`REG_STATUS, 32'h0000000D);
      settle_irq(1'b0);
      av_wr(`REG_MASK, 32'h00000008);
      settle_irq(1'b1);
      av_wr(`REG_STATUS, 32'h00000008);
      settle_irq(1'b0);
      av_rd(`REG_STATUS, 32'h00000005);
      av_wr(`REG_MASK, 32'h0000000F);
      settle_irq(1'b1);
      av_wr(`REG_STATUS, 32'h0000000F);
      settle_irq(1'b0);
      av_rd(`REG_STATUS, 32'h0);
      // millisecond base: ticks run, address hit clears and switches
      av_wr(`REG_STMT, 32'h00000031);
      av_wr(`REG_CTRL, 32'h00000041);
      // frozen clock enable must stop the tick too
      repeat (5 * TICK) @(posedge ref_clk);
      clk_en <= 1'b0;
      repeat (5 * TICK) @(posedge ref_clk);
      clk_en <= 1'b1;
      repeat (5 * TICK) @(posedge ref_clk);
      av_xfer(1'b0, `REG_COUNT, 32'h0, c1);
      check({31'h0, c1 >= n + 8 && c1 <= n + 12}, 32'h1);
      cycle(a0, d0, s0);
      exp_cnt[0]++;
      exp_cnt[1]++;
      pulses();
      av_xfer(1'b0, `REG_COUNT, 32'h0, c1);
      check({31'h0, c1 <= 3}, 32'h1);
      av_rd(`REG_CTRL, 32'h00000043);
      final_report();
   end
endmodule
